/* File: design/gpd_pkg.sv */
`default_nettype none
package gpd_pkg;
    localparam int unsigned NUM_PORTS            = 4;
    localparam int unsigned PORT_WIDTH           = 16;
    // bank stride and register offsets within a bank
    localparam logic [11:0] BANK_STRIDE          = 12'h0100;
    localparam logic [7:0]  OFS_OUTPUT_LEVEL     = 8'h00;
    localparam logic [7:0]  OFS_INPUT_LEVEL      = 8'h04;
    localparam logic [7:0]  OFS_BIT_SET          = 8'h08;
    localparam logic [7:0]  OFS_BIT_CLEAR        = 8'h0c;
    localparam logic [7:0]  OFS_DIR              = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MODE         = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STATUS       = 8'h18;
    localparam logic [7:0]  OFS_IRQ_MASK         = 8'h1c;
    localparam logic [7:0]  OFS_DEB_ENABLE       = 8'h20;
    localparam logic [7:0]  OFS_DEB_CLK_SEL      = 8'h24;
    localparam logic [7:0]  OFS_PORT_ENABLE      = 8'h28;
    // global unlock register, outside the port banks
    localparam logic [11:0] ADDR_UNLOCK          = 12'h0ff0;
    localparam logic [7:0]  UNLOCK_KEY_FIRST     = 8'h15;
    localparam logic [7:0]  UNLOCK_KEY_SECOND    = 8'h51;
    // reset values
    localparam logic [15:0] RST_OUTPUT_LEVEL     = 16'h0000;
    localparam logic [15:0] RST_DIR              = 16'h0000;
    localparam logic [31:0] RST_IRQ_MODE         = 32'h0000_0000;
    localparam logic [15:0] RST_IRQ_MASK         = 16'h0000;
    localparam logic [15:0] RST_DEB_ENABLE       = 16'h0000;
    localparam logic [7:0]  RST_DEB_CLK_SEL      = 8'h00;
    localparam logic [15:0] RST_PORT_ENABLE      = 16'h0000;
    // alternate port enable reset values: no pins enabled at reset
    localparam logic [15:0] RST_PORT_ENABLE_ONE  = 16'h0000;
    localparam logic [15:0] RST_PORT_ENABLE_TWO  = 16'h0000;
    // irq mode codes
    localparam logic [1:0]  IRQ_OFF              = 2'b00;
    localparam logic [1:0]  IRQ_LOW_FALL         = 2'b01;
    localparam logic [1:0]  IRQ_HIGH_RISE        = 2'b10;
    localparam logic [1:0]  IRQ_BOTH             = 2'b11;
    // debounce counter codes and axi response codes
    localparam logic [1:0]  DEB_CNT_ONE          = 2'b01;
    localparam logic [1:0]  DEB_CNT_ZERO         = 2'b10;
    localparam logic [1:0]  AXI_OKAY             = 2'b00;
    localparam logic [1:0]  AXI_SLVERR           = 2'b10;

    typedef enum logic [1:0] {GPD_LOCKED, GPD_HALF, GPD_OPEN} gpd_lock_t;

    typedef struct packed {
        logic [15:0] out_level;
        logic [15:0] dir;
        logic [31:0] irq_mode;
        logic        irq_edge;
        logic [15:0] irq_status;
        logic [15:0] irq_mask;
        logic [15:0] deb_enable;
        logic [7:0]  deb_clk_sel;
        logic [15:0] port_enable;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] deb_level;
        logic [31:0] deb_cnt;
        logic [15:0] in_level;
        logic [15:0] in_prev;
        logic [7:0]  deb_div;
    } gpd_port_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        irq;
    } gpd_bus_t;
endpackage
`default_nettype wire

/* File: design/gpd_top.sv */
// Register access over AXI4-Lite was decided locally.
`default_nettype none
module gpd_top #(
    parameter int unsigned NP = gpd_pkg::NUM_PORTS,
    parameter int unsigned PW = gpd_pkg::PORT_WIDTH
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [13:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [13:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [NP*PW-1:0]  pin_in,
    output logic [NP*PW-1:0]       pin_out,
    output logic [NP*PW-1:0]       pin_oe,
    output logic                   irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    gpd_pkg::gpd_port_t [NP-1:0] port_reg;
    gpd_pkg::gpd_port_t [NP-1:0] port_next;
    gpd_pkg::gpd_bus_t           bus_reg;
    gpd_pkg::gpd_bus_t           bus_next;
    gpd_pkg::gpd_lock_t          lock_reg;
    gpd_pkg::gpd_lock_t          lock_next;
    logic [NP*PW-1:0]            out_pins_reg;
    logic [NP*PW-1:0]            out_pins_next;
    logic [NP*PW-1:0]            oe_pins_reg;
    logic [NP*PW-1:0]            oe_pins_next;

    logic        wr_fire;
    logic        rd_fire;
    logic [11:0] wr_addr;
    logic [11:0] rd_addr;
    logic [1:0]  wr_bank;
    logic [1:0]  rd_bank;
    logic [7:0]  wr_ofs;
    logic [7:0]  rd_ofs;
    logic        wr_bank_ok;
    logic        rd_bank_ok;
    logic [15:0] wmask;
    logic [31:0] wmask32;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic        wr_ok;
    logic        unlocked;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        wr_fire    = bus_reg.aw_held && bus_reg.w_held && !bus_reg.bvalid;
        rd_fire    = s_axi_arvalid && bus_reg.arready;
        wr_addr    = bus_reg.aw_addr;
        rd_addr    = s_axi_araddr[11:0];
        wr_bank    = wr_addr[9:8];
        rd_bank    = rd_addr[9:8];
        wr_ofs     = wr_addr[7:0];
        rd_ofs     = rd_addr[7:0];
        wr_bank_ok = (wr_addr[11:10] == 2'b00) && (32'(wr_bank) < NP);
        rd_bank_ok = (rd_addr[11:10] == 2'b00) && (32'(rd_bank) < NP);
        wmask32    = {{8{bus_reg.w_strb[3]}}, {8{bus_reg.w_strb[2]}},
                      {8{bus_reg.w_strb[1]}}, {8{bus_reg.w_strb[0]}}};
        wmask      = wmask32[15:0];
        unlocked   = (lock_reg == gpd_pkg::GPD_OPEN);
    end

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    always_comb begin
        lock_next = lock_reg;
        if (wr_fire && wr_addr == gpd_pkg::ADDR_UNLOCK && bus_reg.w_strb[0]) begin
            if (bus_reg.w_data[7:0] == gpd_pkg::UNLOCK_KEY_FIRST) begin
                lock_next = gpd_pkg::GPD_HALF;
            end else if (bus_reg.w_data[7:0] == gpd_pkg::UNLOCK_KEY_SECOND &&
                         lock_reg == gpd_pkg::GPD_HALF) begin
                lock_next = gpd_pkg::GPD_OPEN;
            end else begin
                lock_next = gpd_pkg::GPD_LOCKED;
            end
        end else if (rd_fire && lock_reg == gpd_pkg::GPD_HALF) begin
            lock_next = gpd_pkg::GPD_LOCKED;
        end
    end

    // ------------------------------------------------------------
    // per-port logic
    // ------------------------------------------------------------
    for (genvar p = 0; p < NP; p++) begin : g_port
        always_comb begin
            gpd_pkg::gpd_port_t s;
            logic               tick;
            logic [15:0]        raw;
            logic [15:0]        rise;
            logic [15:0]        fall;
            logic [15:0]        hit;
            logic               sel;
            s    = port_reg[p];
            tick = (s.deb_div == s.deb_clk_sel);
            raw  = '0;
            rise = '0;
            fall = '0;
            hit  = '0;
            sel  = wr_fire && wr_bank_ok && (32'(wr_bank) == p);
            s.sync1 = pin_in[p*PW +: PW];
            s.sync2 = port_reg[p].sync1;
            s.deb_div = tick ? 8'h00 : 8'(s.deb_div + 8'h01);
            for (int b = 0; b < PW; b++) begin
                if (tick) begin
                    s.deb_cnt[2*b +: 2] = {s.deb_cnt[2*b], port_reg[p].sync2[b]};
                end
                if (s.deb_cnt[2*b +: 2] == gpd_pkg::DEB_CNT_ONE) begin
                    s.deb_level[b] = 1'b1;
                end else if (s.deb_cnt[2*b +: 2] == gpd_pkg::DEB_CNT_ZERO) begin
                    s.deb_level[b] = 1'b0;
                end
                raw[b] = port_reg[p].deb_enable[b] ? port_reg[p].deb_level[b]
                                                   : port_reg[p].sync2[b];
            end
            s.in_level = raw;
            s.in_prev  = port_reg[p].in_level;
            rise = s.in_level & ~port_reg[p].in_level;
            fall = ~s.in_level & port_reg[p].in_level;
            for (int b = 0; b < PW; b++) begin
                unique case (port_reg[p].irq_mode[2*b +: 2])
                    gpd_pkg::IRQ_OFF:       hit[b] = 1'b0;
                    gpd_pkg::IRQ_LOW_FALL:  hit[b] = port_reg[p].irq_edge ? fall[b] : ~raw[b];
                    gpd_pkg::IRQ_HIGH_RISE: hit[b] = port_reg[p].irq_edge ? rise[b] : raw[b];
                    gpd_pkg::IRQ_BOTH:      hit[b] = port_reg[p].irq_edge & (rise[b] | fall[b]);
                endcase
            end
            if (sel) begin
                unique case (wr_ofs)
                    gpd_pkg::OFS_OUTPUT_LEVEL:
                        s.out_level = (s.out_level & ~wmask) | (bus_reg.w_data[15:0] & wmask);
                    gpd_pkg::OFS_BIT_SET:
                        s.out_level = s.out_level | (bus_reg.w_data[15:0] & wmask);
                    gpd_pkg::OFS_BIT_CLEAR:
                        s.out_level = s.out_level & ~(bus_reg.w_data[15:0] & wmask);
                    gpd_pkg::OFS_IRQ_STATUS:
                        s.irq_status = s.irq_status & ~(bus_reg.w_data[15:0] & wmask);
                    gpd_pkg::OFS_IRQ_MASK:
                        s.irq_mask = (s.irq_mask & ~wmask) | (bus_reg.w_data[15:0] & wmask);
                    default: begin
                        if (unlocked) begin
                            unique case (wr_ofs)
                                gpd_pkg::OFS_DIR:
                                    s.dir = (s.dir & ~wmask) | (bus_reg.w_data[15:0] & wmask);
                                gpd_pkg::OFS_IRQ_MODE: begin
                                    s.irq_mode = (s.irq_mode & ~wmask32) | (bus_reg.w_data & wmask32);
                                end
                                gpd_pkg::OFS_DEB_ENABLE: begin
                                    s.deb_enable = (s.deb_enable & ~wmask) | (bus_reg.w_data[15:0] & wmask);
                                    if (bus_reg.w_strb[2]) begin
                                        s.irq_edge = bus_reg.w_data[16];
                                    end
                                end
                                gpd_pkg::OFS_DEB_CLK_SEL:
                                    if (bus_reg.w_strb[0]) begin
                                        s.deb_clk_sel = bus_reg.w_data[7:0];
                                    end
                                gpd_pkg::OFS_PORT_ENABLE:
                                    s.port_enable = (s.port_enable & ~wmask) | (bus_reg.w_data[15:0] & wmask);
                                default: s.dir = s.dir;
                            endcase
                        end
                    end
                endcase
            end
            s.irq_status = s.irq_status | hit;  // set wins over clear
            port_next[p] = s;
            // driver on only for enabled output pins
            out_pins_next[p*PW +: PW] = port_reg[p].out_level;
            oe_pins_next[p*PW +: PW]  = port_reg[p].dir & port_reg[p].port_enable;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = rd_bank_ok;
        if (rd_addr == gpd_pkg::ADDR_UNLOCK) begin
            rd_ok = 1'b1;
        end else if (rd_bank_ok) begin
            unique case (rd_ofs)
                gpd_pkg::OFS_OUTPUT_LEVEL: rd_word = {16'h0000, port_reg[rd_bank].out_level};
                gpd_pkg::OFS_INPUT_LEVEL:  rd_word = {16'h0000, port_reg[rd_bank].in_level};
                gpd_pkg::OFS_BIT_SET:      rd_word = 32'h0000_0000;
                gpd_pkg::OFS_BIT_CLEAR:    rd_word = 32'h0000_0000;
                gpd_pkg::OFS_DIR:          rd_word = {16'h0000, port_reg[rd_bank].dir};
                gpd_pkg::OFS_IRQ_MODE:     rd_word = port_reg[rd_bank].irq_mode;
                gpd_pkg::OFS_IRQ_STATUS:   rd_word = {16'h0000, port_reg[rd_bank].irq_status};
                gpd_pkg::OFS_IRQ_MASK:     rd_word = {16'h0000, port_reg[rd_bank].irq_mask};
                gpd_pkg::OFS_DEB_ENABLE:
                    rd_word = {15'h0000, port_reg[rd_bank].irq_edge, port_reg[rd_bank].deb_enable};
                gpd_pkg::OFS_DEB_CLK_SEL:  rd_word = {24'h00_0000, port_reg[rd_bank].deb_clk_sel};
                gpd_pkg::OFS_PORT_ENABLE:  rd_word = {16'h0000, port_reg[rd_bank].port_enable};
                default:                   rd_ok = 1'b0;
            endcase
        end
        wr_ok = (wr_addr == gpd_pkg::ADDR_UNLOCK) ||
                (wr_bank_ok && wr_ofs <= gpd_pkg::OFS_PORT_ENABLE && wr_ofs[1:0] == 2'b00);
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    always_comb begin
        logic any_irq;
        any_irq  = 1'b0;
        bus_next = bus_reg;
        for (int p = 0; p < NP; p++) begin
            any_irq = any_irq | (|(port_next[p].irq_status & port_next[p].irq_mask));
        end
        bus_next.irq = any_irq;
        if (s_axi_awvalid && bus_reg.awready) begin
            bus_next.aw_held = 1'b1;
            bus_next.aw_addr = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && bus_reg.wready) begin
            bus_next.w_held = 1'b1;
            bus_next.w_data = s_axi_wdata;
            bus_next.w_strb = s_axi_wstrb;
        end
        bus_next.awready = !bus_next.aw_held;
        bus_next.wready  = !bus_next.w_held;
        if (wr_fire) begin
            bus_next.bvalid = 1'b1;
            bus_next.bresp  = wr_ok ? gpd_pkg::AXI_OKAY : gpd_pkg::AXI_SLVERR;
        end
        if (bus_reg.bvalid && s_axi_bready) begin
            bus_next.bvalid  = 1'b0;
            bus_next.aw_held = 1'b0;
            bus_next.w_held  = 1'b0;
            bus_next.awready = 1'b1;
            bus_next.wready  = 1'b1;
        end
        if (rd_fire) begin
            bus_next.arready = 1'b0;
            bus_next.rvalid  = 1'b1;
            bus_next.rdata   = rd_word;
            bus_next.rresp   = rd_ok ? gpd_pkg::AXI_OKAY : gpd_pkg::AXI_SLVERR;
        end
        if (bus_reg.rvalid && s_axi_rready) begin
            bus_next.rvalid  = 1'b0;
            bus_next.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < NP; p++) begin
                port_reg[p]             <= '0;
                port_reg[p].out_level   <= gpd_pkg::RST_OUTPUT_LEVEL;
                port_reg[p].dir         <= gpd_pkg::RST_DIR;
                port_reg[p].irq_mode    <= gpd_pkg::RST_IRQ_MODE;
                port_reg[p].irq_mask    <= gpd_pkg::RST_IRQ_MASK;
                port_reg[p].deb_enable  <= gpd_pkg::RST_DEB_ENABLE;
                port_reg[p].deb_clk_sel <= gpd_pkg::RST_DEB_CLK_SEL;
                port_reg[p].port_enable <= gpd_pkg::RST_PORT_ENABLE;
            end
            bus_reg         <= '0;
            bus_reg.awready <= 1'b1;
            bus_reg.wready  <= 1'b1;
            bus_reg.arready <= 1'b1;
            lock_reg        <= gpd_pkg::GPD_LOCKED;
            out_pins_reg    <= '0;
            oe_pins_reg     <= '0;
        end else begin
            port_reg     <= port_next;
            bus_reg      <= bus_next;
            lock_reg     <= lock_next;
            out_pins_reg <= out_pins_next;
            oe_pins_reg  <= oe_pins_next;
        end
    end

    always_comb begin
        s_axi_awready = bus_reg.awready;
        s_axi_wready  = bus_reg.wready;
        s_axi_bvalid  = bus_reg.bvalid;
        s_axi_bresp   = bus_reg.bresp;
        s_axi_arready = bus_reg.arready;
        s_axi_rvalid  = bus_reg.rvalid;
        s_axi_rdata   = bus_reg.rdata;
        s_axi_rresp   = bus_reg.rresp;
        pin_out       = out_pins_reg;
        pin_oe        = oe_pins_reg;
        irq           = bus_reg.irq;
    end
endmodule
`default_nettype wire

/* File: bench/gpd_top_sva.sv */
`default_nettype none
module gpd_top_sva #(
    parameter int unsigned NP = gpd_pkg::NUM_PORTS,
    parameter int unsigned PW = gpd_pkg::PORT_WIDTH
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic [13:0]      s_axi_awaddr,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic [31:0]      s_axi_wdata,
    input wire logic [3:0]       s_axi_wstrb,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [13:0]      s_axi_araddr,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [NP*PW-1:0] pin_in,
    input wire logic [NP*PW-1:0] pin_out,
    input wire logic [NP*PW-1:0] pin_oe,
    input wire logic             irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hf;
    wire logic rd_take = s_axi_arvalid && s_axi_arready;
    a_write_answer: assert property (wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_setclr_read_zero: assert property (
        rd_take && s_axi_araddr[9:0] inside {10'h008, 10'h00c} |=> s_axi_rdata == 32'h0000_0000)
        else $error("set or clear read not zero");
    a_set_bits: assert property (
        wr_take && s_axi_awaddr == 14'h0008 |=> ##2
        (pin_out[15:0] & $past(s_axi_wdata[15:0], 3)) == $past(s_axi_wdata[15:0], 3))
        else $error("set bits not driven high");
    a_clear_bits: assert property (
        wr_take && s_axi_awaddr == 14'h000c |=> ##2 (pin_out[15:0] & $past(s_axi_wdata[15:0], 3)) == 16'h0000)
        else $error("clear bits not driven low");
    a_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> pin_oe == '0 && pin_out == '0 && !irq)
        else $error("pins or irq active after reset");
endmodule
bind gpd_top gpd_top_sva #(.NP(NP), .PW(PW)) u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_in, .pin_out, .pin_oe, .irq);
`default_nettype wire

/* File: bench/gpd_board.sv */
`default_nettype none
module gpd_board (
    input  wire logic [63:0] pin_out,
    input  wire logic [63:0] pin_oe,
    input  wire logic [63:0] ext_level,
    output logic      [63:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // pad shows own driver where enabled, else the board level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

/* File: bench/gpd_top_test.sv */
`default_nettype none
module gpd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [13:0] awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, got;
    logic [63:0] ext = '0;
    logic [15:0] out_m [4], v;
    logic [1:0]  rsp;
    wire  logic  awready, wready, bvalid, arready, rvalid, irq;
    wire  logic [1:0] bresp, rresp;
    wire  logic [31:0] rdata;
    wire  logic [63:0] pin_in, pin_out, pin_oe;
    integer      seed = 32'h5b9f_27c0;
    int          err_total = 0, compares = 0, p, op;
    always #4 aclk = ~aclk;
    gpd_top uut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in, .pin_out, .pin_oe, .irq);
    gpd_board u_board (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
    //------------------------------------------------------------
    // bus tasks and checks
    //------------------------------------------------------------
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 60);
        if (bvalid !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [13:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 60);
        if (rvalid !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        got = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    function automatic logic [13:0] ra(input int q, input logic [7:0] o);
        return {4'h0, q[1:0], o};
    endfunction
    function automatic logic [15:0] next_out(input int k, input logic [15:0] old, input logic [15:0] d);
        return (k == 0) ? d : (k == 1) ? (old | d) : (old & ~d);
    endfunction
    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) out_m[i] = 16'h0000;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            rd(ra(i, gpd_pkg::OFS_OUTPUT_LEVEL));
            chk(got, 32'h0000_0000);
            rd(ra(i, gpd_pkg::OFS_BIT_SET));
            chk(got, 32'h0000_0000);
            rd(ra(i, gpd_pkg::OFS_BIT_CLEAR));
            chk(got, 32'h0000_0000);
        end
        rd(14'h002c);
        chk({30'h0, rsp}, {30'h0, gpd_pkg::AXI_SLVERR});
        $display("test reset done");
        wr(ra(1, gpd_pkg::OFS_DIR), 32'h0000_ffff);
        chk({30'h0, rsp}, {30'h0, gpd_pkg::AXI_OKAY});
        rd(ra(1, gpd_pkg::OFS_DIR));
        chk(got, 32'h0000_0000);
        wr(14'h0ff0, 32'h0000_0015);
        wr(14'h0ff0, 32'h0000_0051);
        wr(ra(1, gpd_pkg::OFS_DIR), 32'h0000_ffff);
        wr(ra(1, gpd_pkg::OFS_PORT_ENABLE), 32'h0000_ffff);
        rd(ra(1, gpd_pkg::OFS_DIR));
        chk(got, 32'h0000_ffff);
        repeat (2) @(posedge aclk);
        chk(pin_oe[63:32], 32'h0000_0000);
        chk(pin_oe[31:0], 32'hffff_0000);
        wr(14'h0ff0, 32'h0000_0000);
        wr(ra(1, gpd_pkg::OFS_DIR), 32'h0000_0000);
        rd(ra(1, gpd_pkg::OFS_DIR));
        chk(got, 32'h0000_ffff);
        wr(14'h0ff0, 32'h0000_0015);
        rd(ra(0, gpd_pkg::OFS_OUTPUT_LEVEL));
        wr(14'h0ff0, 32'h0000_0051);
        wr(ra(1, gpd_pkg::OFS_DIR), 32'h0000_0000);
        rd(ra(1, gpd_pkg::OFS_DIR));
        chk(got, 32'h0000_ffff);
        $display("test lock done");
        repeat (24) begin
            p = $unsigned($random(seed)) % 4;
            op = $unsigned($random(seed)) % 3;
            v = 16'($random(seed));
            ext <= {$random(seed), $random(seed)};
            out_m[p] = next_out(op, out_m[p], v);
            wr(ra(p, op == 0 ? gpd_pkg::OFS_OUTPUT_LEVEL : op == 1 ? gpd_pkg::OFS_BIT_SET
                : gpd_pkg::OFS_BIT_CLEAR), {16'h0000, v});
            repeat (6) @(posedge aclk);
            chk({16'h0000, pin_out[p*16 +: 16]}, {16'h0000, out_m[p]});
            rd(ra(p, gpd_pkg::OFS_INPUT_LEVEL));
            chk(got, {16'h0000, p == 1 ? out_m[1] : ext[p*16 +: 16]});
        end
        $display("test data done");
        ext <= 64'h0000_0000_0000_0000;
        wr(14'h0ff0, 32'h0000_0015);
        wr(14'h0ff0, 32'h0000_0051);
        for (int m = 3; m >= 0; m--) begin
            wr(ra(3, gpd_pkg::OFS_IRQ_MODE), {30'h0, 2'(m)});
            rd(ra(3, gpd_pkg::OFS_IRQ_MODE));
            chk(got, {30'h0, 2'(m)});
        end
        wr(ra(3, gpd_pkg::OFS_IRQ_MODE), {30'h0, gpd_pkg::IRQ_HIGH_RISE});
        wr(ra(3, gpd_pkg::OFS_IRQ_STATUS), 32'h0000_0001);
        rd(ra(3, gpd_pkg::OFS_IRQ_STATUS));
        chk(got, 32'h0000_0000);
        wr(ra(3, gpd_pkg::OFS_PORT_ENABLE), 32'h0000_ffff);
        ext <= 64'h0001_0000_0000_0000;
        repeat (8) @(posedge aclk);
        rd(ra(3, gpd_pkg::OFS_IRQ_STATUS));
        chk(got, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(ra(3, gpd_pkg::OFS_IRQ_MASK), 32'h0000_0001);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        ext <= 64'h0000_0000_0000_0000;
        repeat (8) @(posedge aclk);
        wr(ra(3, gpd_pkg::OFS_IRQ_STATUS), 32'h0000_0001);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test irq done");
        wr(ra(0, gpd_pkg::OFS_DEB_CLK_SEL), 32'h0000_00ff);
        wr(ra(0, gpd_pkg::OFS_DEB_ENABLE), 32'h0000_0001);
        ext <= 64'h0000_0000_0000_0001;
        repeat (8) @(posedge aclk);
        rd(ra(0, gpd_pkg::OFS_INPUT_LEVEL));
        chk(got, 32'h0000_0000);
        repeat (300) @(posedge aclk);
        rd(ra(0, gpd_pkg::OFS_INPUT_LEVEL));
        chk(got, 32'h0000_0001);
        $display("test debounce done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
